// ==== rtl/pcc_top.sv ====
// Clock conditioning block: dividers, delays, lock and register slave
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module pcc_top #(
	parameter int LOCK_COUNT = pcc_pkg::LOCK_PERIODS
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Reference sources
	input wire logic REF_GLOBAL_PIN,
	input wire logic REF_IO_PIN,
	input wire logic REF_CORE,
	input wire logic REF_RC_OSC,
	input wire logic REF_XTAL_OSC,
	// Loop controls
	input wire logic EXTERNAL_FEEDBACK_IN,
	input wire logic PLL_SLEEP_N,
	input wire logic OUT_A_DIVIDER_RESET,
	input wire logic OUT_A_HALF_STEP_DIVIDE,
	// Derived clocks and lock
	output logic PRIMARY_GLOBAL_CLK,
	output logic SECONDARY_GLOBAL_CLK_1,
	output logic SECONDARY_GLOBAL_CLK_2,
	output logic CORE_ROUTE_CLK_1,
	output logic CORE_ROUTE_CLK_2,
	output logic LOCK,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [7:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA
);
	localparam int DD = pcc_pkg::DLY_DEPTH;

	logic [31:0] ctrl_q;
	logic [31:0] div_q;
	logic [31:0] dly_q;
	logic wr_q;
	logic [7:0] addr_q;
	logic [31:0] rdata_q;
	logic ref_mux, ref_d_q;
	logic [1:0][4:0] pin_s;
	logic [2:0] fb_s;
	logic [1:0] sleep_s;
	logic [2:0] drst_s;
	logic [1:0] half_s;
	logic ref_rise;
	logic ref_fall;
	logic ext_rise;
	logic int_fb_q;
	logic fb_pulse;
	logic awake;
	logic bypass;
	logic drst_edge;
	logic lock_int;
	logic lock_d1_q;
	logic int_sync;
	logic [4:0] en_eff;
	logic [DD-1:0] line_a_q;
	logic [DD-1:0] line_b_q;
	logic [DD-1:0] line_c_q;
	logic [4:0] out_q;

	pcc_div_if dv_a ();
	pcc_div_if dv_b ();
	pcc_div_if dv_c ();

	// Tap of a delay line
	function automatic logic tap(input logic [DD-1:0] line, input logic [3:0] sel);
		return line[sel];
	endfunction : tap

	// Legal output sets from requested enables: pri, sec1, core1, sec2, core2
	function automatic logic [4:0] legal_set(input logic [4:0] req);
		logic [4:0] r;
		r = 5'h0;
		r[0] = req[0];
		r[2:1] = req[0] ? req[2:1] : 2'b00;
		r[4:3] = (req[0] && (req[1] || req[2])) ? req[4:3] : 2'b00;
		return r;
	endfunction : legal_set
	// Reference source multiplexer behind the candidate synchronisers
	always_comb begin
		case (pcc_pkg::pcc_ref_t'(ctrl_q[pcc_pkg::REFSEL_POS +: 3]))
			pcc_pkg::REF_GLOBAL: ref_mux = pin_s[1][0];
			pcc_pkg::REF_IO: ref_mux = pin_s[1][1];
			pcc_pkg::REF_CORE: ref_mux = pin_s[1][2];
			pcc_pkg::REF_INT_RC: ref_mux = pin_s[1][3];
			pcc_pkg::REF_XTAL: ref_mux = pin_s[1][4];
			default: ref_mux = 1'b0;
		endcase
	end

	// Two-stage synchronisers, third stage for edge finding
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_s <= '0;
			ref_d_q <= 1'b0;
			fb_s <= 3'h0;
			drst_s <= 3'h0;
			sleep_s <= 2'h0;
			half_s <= 2'h0;
		end else begin
			pin_s <= {pin_s[0], {REF_XTAL_OSC, REF_RC_OSC, REF_CORE, REF_IO_PIN, REF_GLOBAL_PIN}};
			ref_d_q <= ref_mux;
			fb_s <= {fb_s[1:0], EXTERNAL_FEEDBACK_IN};
			drst_s <= {drst_s[1:0], OUT_A_DIVIDER_RESET};
			sleep_s <= {sleep_s[0], PLL_SLEEP_N};
			half_s <= {half_s[0], OUT_A_HALF_STEP_DIVIDE};
		end
	end

	assign ref_rise = ref_mux & ~ref_d_q;
	assign ref_fall = ~ref_mux & ref_d_q;
	assign ext_rise = fb_s[1] & ~fb_s[2];
	assign drst_edge = drst_s[1] & ~drst_s[2];
	assign awake = sleep_s[1];
	assign bypass = (ctrl_q[pcc_pkg::SRC_POS +: 3] == pcc_pkg::SRC_BYPASS);
	assign en_eff = legal_set(ctrl_q[pcc_pkg::EN_POS +: 5]);

	// Internal feedback path follows the reference by one cycle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			int_fb_q <= 1'b0;
		end else begin
			int_fb_q <= ref_rise;
		end
	end

	// Feedback choice for the phase detector
	assign fb_pulse = ctrl_q[pcc_pkg::EXT_FB_POS] ? ext_rise : int_fb_q;

	pcc_lock_det #(
		.LOCK_COUNT(LOCK_COUNT)
	) u_lock (
		.clk(CLK),
		.rst_b(RST_B),
		.clear(!awake || bypass),
		.ref_rise(ref_rise),
		.fb_rise(fb_pulse),
		.lock(lock_int)
	);

	// Lock edge drives the internal divider sync reset
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			lock_d1_q <= 1'b0;
		end else begin
			lock_d1_q <= lock_int;
		end
	end

	assign int_sync = !bypass && lock_int && !lock_d1_q;

	// Divider A: pin reset only in bypass, half step only in bypass
	assign dv_a.rise = ref_rise;
	assign dv_a.fall = ref_fall;
	assign dv_a.lvl = ref_d_q;
	assign dv_a.half = bypass && half_s[1];
	assign dv_a.sync_rst = bypass ? drst_edge : int_sync;
	assign dv_a.run = awake;
	assign dv_a.ratio = div_q[pcc_pkg::DIVA_POS +: 4];

	// Dividers B and C follow the internal sync only
	assign dv_b.rise = ref_rise;
	assign dv_b.fall = ref_fall;
	assign dv_b.lvl = ref_d_q;
	assign dv_b.half = 1'b0;
	assign dv_b.sync_rst = int_sync;
	assign dv_b.run = awake;
	assign dv_b.ratio = div_q[pcc_pkg::DIVB_POS +: 4];
	assign dv_c.rise = ref_rise;
	assign dv_c.fall = ref_fall;
	assign dv_c.lvl = ref_d_q;
	assign dv_c.half = 1'b0;
	assign dv_c.sync_rst = int_sync;
	assign dv_c.run = awake;
	assign dv_c.ratio = div_q[pcc_pkg::DIVC_POS +: 4];

	pcc_divider u_div_a (.clk(CLK), .rst_b(RST_B), .dv(dv_a.div));
	pcc_divider u_div_b (.clk(CLK), .rst_b(RST_B), .dv(dv_b.div));
	pcc_divider u_div_c (.clk(CLK), .rst_b(RST_B), .dv(dv_c.div));

	// One delay line per global path; core taps share the secondary lines
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			line_a_q <= '0;
			line_b_q <= '0;
			line_c_q <= '0;
		end else begin
			line_a_q <= {line_a_q[DD-2:0], dv_a.clk_out};
			line_b_q <= {line_b_q[DD-2:0], dv_b.clk_out};
			line_c_q <= {line_c_q[DD-2:0], dv_c.clk_out};
		end
	end

	// Registered outputs, forced low while asleep
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			out_q <= 5'h0;
		end else if (!awake) begin
			out_q <= 5'h0;
		end else begin
			out_q[0] <= en_eff[0] && tap(line_a_q, {1'b0, dly_q[pcc_pkg::DLYA_POS +: 3]});
			out_q[1] <= en_eff[1] && tap(line_b_q, {1'b0, dly_q[pcc_pkg::DLYB_POS +: 3]});
			out_q[2] <= en_eff[2] && tap(line_b_q, dly_q[pcc_pkg::DLYYB_POS +: 4]);
			out_q[3] <= en_eff[3] && tap(line_c_q, {1'b0, dly_q[pcc_pkg::DLYC_POS +: 3]});
			out_q[4] <= en_eff[4] && tap(line_c_q, dly_q[pcc_pkg::DLYYC_POS +: 4]);
		end
	end

	assign PRIMARY_GLOBAL_CLK = out_q[0];
	assign SECONDARY_GLOBAL_CLK_1 = out_q[1];
	assign CORE_ROUTE_CLK_1 = out_q[2];
	assign SECONDARY_GLOBAL_CLK_2 = out_q[3];
	assign CORE_ROUTE_CLK_2 = out_q[4];
	assign LOCK = lock_int;

	// Bus address phase capture; zero wait states
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			wr_q <= 1'b0;
			addr_q <= 8'h0;
		end else if (HREADY) begin
			wr_q <= HSEL && HTRANS[1] && HWRITE;
			addr_q <= HADDR;
		end
	end

	// Register writes in the data phase
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ctrl_q <= pcc_pkg::CTRL_RST;
			div_q <= pcc_pkg::DIV_RST;
			dly_q <= pcc_pkg::DLY_RST;
		end else if (wr_q) begin
			case (addr_q)
				pcc_pkg::CTRL_OFS: ctrl_q <= HWDATA & 32'h0000_1F7F;
				pcc_pkg::DIV_OFS: div_q <= HWDATA & 32'h0000_0FFF;
				pcc_pkg::DLY_OFS: dly_q <= HWDATA & 32'h0001_FFFF;
				default: ;
			endcase
		end
	end

	// Read data prepared at the address phase; unmapped reads zero
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rdata_q <= 32'h0000_0000;
		end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
			case (HADDR)
				pcc_pkg::CTRL_OFS: rdata_q <= ctrl_q;
				pcc_pkg::DIV_OFS: rdata_q <= div_q;
				pcc_pkg::DLY_OFS: rdata_q <= dly_q;
				pcc_pkg::STAT_OFS: begin
					rdata_q <= 32'h0000_0000;
					rdata_q[pcc_pkg::ST_LOCK_POS] <= lock_int;
					rdata_q[pcc_pkg::ST_SLEEP_POS] <= !awake;
					rdata_q[pcc_pkg::ST_BYP_POS] <= bypass;
					rdata_q[pcc_pkg::ST_EN_POS +: 5] <= en_eff;
				end
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign HRDATA = rdata_q;
	// Assertions
	property p_sleep_quiet;
		@(posedge CLK) disable iff (!RST_B)
		!awake |=> (out_q == 5'h0);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("clock out while asleep");
	property p_sleep_unlock;
		@(posedge CLK) disable iff (!RST_B)
		!awake |=> ##1 !LOCK;
	endproperty
	a_sleep_unlock: assert property (p_sleep_unlock) else $error("lock high in power-down");
	property p_pin_reset_bypass;
		@(posedge CLK) disable iff (!RST_B)
		(bypass && drst_edge && awake) |=> (u_div_a.cnt_q == 5'h0);
	endproperty
	a_pin_reset_bypass: assert property (p_pin_reset_bypass) else $error("pin reset lost");
	property p_pin_ignored_core;
		@(posedge CLK) disable iff (!RST_B)
		(!bypass && drst_edge && !(lock_int && !lock_d1_q)) |-> !dv_a.sync_rst;
	endproperty
	a_pin_ignored_core: assert property (p_pin_ignored_core) else $error("pin reset in core mode");
	property p_ext_feedback;
		@(posedge CLK) disable iff (!RST_B)
		ctrl_q[pcc_pkg::EXT_FB_POS] |-> (fb_pulse == ext_rise);
	endproperty
	a_ext_feedback: assert property (p_ext_feedback) else $error("wrong feedback source");
	property p_out_sets;
		@(posedge CLK) disable iff (!RST_B)
		(out_q[2:1] != 2'b00 |-> $past(en_eff[0])) and
			(out_q[4:3] != 2'b00 |-> ($past(en_eff[1]) || $past(en_eff[2])));
	endproperty
	a_out_sets: assert property (p_out_sets) else $error("illegal output set");
	sequence s_core_same_tap;
		awake && en_eff[1] && en_eff[2] && ({1'b0, dly_q[pcc_pkg::DLYB_POS +: 3]} == dly_q[pcc_pkg::DLYYB_POS +: 4]);
	endsequence
	property p_core_tracks;
		@(posedge CLK) disable iff (!RST_B)
		s_core_same_tap ##1 $stable(dly_q) |-> (CORE_ROUTE_CLK_1 == SECONDARY_GLOBAL_CLK_1);
	endproperty
	a_core_tracks: assert property (p_core_tracks) else $error("core clock differs");
	property p_lock_bypass_low;
		@(posedge CLK) disable iff (!RST_B)
		(bypass [*2]) |=> !LOCK;
	endproperty
	a_lock_bypass_low: assert property (p_lock_bypass_low) else $error("lock in bypass");
endmodule : pcc_top

// ==== rtl/pcc_pkg.sv ====
// Constants shared by the clock conditioning block and its helpers
package pcc_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] DIV_OFS = 8'h04;
	localparam logic [7:0] DLY_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	// Control register fields
	localparam int SRC_POS = 0;
	localparam int REFSEL_POS = 3;
	localparam int EXT_FB_POS = 6;
	localparam int EN_POS = 8;
	// Divider register fields, four bits per channel
	localparam int DIVA_POS = 0;
	localparam int DIVB_POS = 4;
	localparam int DIVC_POS = 8;
	// Delay register fields: globals three bits, core outputs four bits
	localparam int DLYA_POS = 0;
	localparam int DLYB_POS = 3;
	localparam int DLYC_POS = 6;
	localparam int DLYYB_POS = 9;
	localparam int DLYYC_POS = 13;
	// Status register fields
	localparam int ST_LOCK_POS = 0;
	localparam int ST_SLEEP_POS = 1;
	localparam int ST_BYP_POS = 2;
	localparam int ST_EN_POS = 4;
	// Values after reset
	localparam logic [31:0] CTRL_RST = 32'h0000_0100;
	localparam logic [31:0] DIV_RST = 32'h0000_0111;
	localparam logic [31:0] DLY_RST = 32'h0000_0000;
	// Output A source code that bypasses the core
	localparam logic [2:0] SRC_BYPASS = 3'h1;
	// Reference source choices
	typedef enum logic [2:0] {REF_GLOBAL, REF_IO, REF_CORE, REF_INT_RC, REF_XTAL} pcc_ref_t;
	// Default count of good reference periods before lock
	localparam int LOCK_PERIODS = 8;
	// Delay line depth in clock cycles
	localparam int DLY_DEPTH = 16;
endpackage : pcc_pkg

// ==== rtl/pcc_div_if.sv ====
// Connection between the top and one output divider
`timescale 1ns/1ps
interface pcc_div_if;
	logic rise;
	logic fall;
	logic lvl;
	logic half;
	logic sync_rst;
	logic run;
	logic [3:0] ratio;
	logic clk_out;
	modport ctl (output rise, fall, lvl, half, sync_rst, run, ratio, input clk_out);
	modport div (input rise, fall, lvl, half, sync_rst, run, ratio, output clk_out);
endinterface : pcc_div_if

// ==== rtl/pcc_divider.sv ====
// Output divider with whole and half-step ratios
`timescale 1ns/1ps
module pcc_divider (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control and result
	pcc_div_if.div dv
);
	logic [4:0] cnt_q;
	logic out_q;
	logic step;
	logic [4:0] wrap;
	logic [4:0] hi;
	logic [3:0] n;

	// Ratio zero acts as one; half steps count both edges
	always_comb begin
		n = (dv.ratio == 4'h0) ? 4'h1 : dv.ratio;
		step = dv.half ? (dv.rise | dv.fall) : dv.rise;
		wrap = dv.half ? {n, 1'b0} : ({1'b0, n} - 5'h1);
		hi = dv.half ? ({1'b0, n} + 5'h1) : 5'(({1'b0, n} + 5'h1) >> 1);
	end

	// Edge counter, cleared by sync reset so output restarts aligned
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 5'h0;
		end else if (!dv.run || dv.sync_rst) begin
			cnt_q <= 5'h0;
		end else if (step) begin
			cnt_q <= (cnt_q >= wrap) ? 5'h0 : cnt_q + 5'h1;
		end
	end

	// Registered divided clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			out_q <= 1'b0;
		end else if (!dv.run) begin
			out_q <= 1'b0;
		end else if (n == 4'h1 && !dv.half) begin
			out_q <= dv.lvl;
		end else begin
			out_q <= (cnt_q < hi);
		end
	end

	assign dv.clk_out = out_q;

	// Half-step mode: period of 2n+1 half periods of the input
	property p_half_wrap;
		@(posedge clk) disable iff (!rst_b)
		(dv.run && dv.half && !dv.sync_rst && step && cnt_q == {n, 1'b0}) |=> (cnt_q == 5'h0);
	endproperty
	a_half_wrap: assert property (p_half_wrap) else $error("half-step count did not wrap");

	// A whole-ratio step never lands past n-1, even right after a ratio change
	property p_whole_bound;
		@(posedge clk) disable iff (!rst_b)
		(dv.run && !dv.half && !dv.sync_rst && step && dv.ratio > 4'h1) |=>
			(cnt_q < {1'b0, $past(dv.ratio)});
	endproperty
	a_whole_bound: assert property (p_whole_bound) else $error("divider count out of range");
endmodule : pcc_divider

// ==== rtl/pcc_lock_det.sv ====
// Lock detector comparing feedback edges against reference periods
`timescale 1ns/1ps
module pcc_lock_det #(
	parameter int LOCK_COUNT = pcc_pkg::LOCK_PERIODS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Phase detector inputs
	input wire logic clear,
	input wire logic ref_rise,
	input wire logic fb_rise,
	// Lock result
	output logic lock
);
	logic seen_q;
	logic [7:0] hits_q;
	logic lock_q;

	// Note a feedback edge inside the current reference period
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seen_q <= 1'b0;
		end else if (clear) begin
			seen_q <= 1'b0;
		end else if (ref_rise) begin
			seen_q <= fb_rise;
		end else if (fb_rise) begin
			seen_q <= 1'b1;
		end
	end

	// Run of good periods; a miss starts it again
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hits_q <= 8'h0;
		end else if (clear) begin
			hits_q <= 8'h0;
		end else if (ref_rise) begin
			if (!seen_q) begin
				hits_q <= 8'h0;
			end else if (hits_q != 8'hFF) begin
				hits_q <= hits_q + 8'h1;
			end
		end
	end

	// Lock only after a steady run, dropped while cleared
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_q <= 1'b0;
		end else begin
			lock_q <= !clear && (hits_q >= 8'(LOCK_COUNT));
		end
	end

	assign lock = lock_q;

	property p_lock_needs_run;
		@(posedge clk) disable iff (!rst_b)
		$rose(lock_q) |-> ($past(hits_q) >= 8'(LOCK_COUNT));
	endproperty
	a_lock_needs_run: assert property (p_lock_needs_run) else $error("lock without steady run");

	property p_miss_drops;
		@(posedge clk) disable iff (!rst_b)
		(ref_rise && !seen_q && !clear) |-> ##2 !lock_q;
	endproperty
	a_miss_drops: assert property (p_miss_drops) else $error("lock held after missed edge");
endmodule : pcc_lock_det

// ==== tb/pcc_fabric_model.sv ====
// Fabric side model: reference candidates and external feedback
`timescale 1ns/1ps
module pcc_fabric_model (
	// Reference control from the bench
	input wire logic run,
	input wire logic [2:0] sel,
	input wire logic fb_on,
	// Candidate reference pins and feedback pin
	output logic [4:0] ref_pins,
	output logic ext_fb
);
	logic ref_q = 1'b0;
	// 800 ns reference, phase offset to the system clock, held low when stopped
	initial begin
		#37;
		forever begin
			#400;
			ref_q = run ? ~ref_q : 1'b0;
		end
	end
	// Only the chosen candidate carries the clock
	always_comb begin
		ref_pins = 5'h00;
		if (sel < 3'h5) ref_pins[sel] = ref_q;
	end
	// Feedback returns one system cycle late, or stays low when cut
	initial ext_fb = 1'b0;
	always @(ref_q) ext_fb <= #100 (fb_on & ref_q);
endmodule : pcc_fabric_model

// ==== tb/tb_pcc_top.sv ====
// Bench for the clock conditioning block with a register image model
`timescale 1ns/1ps
module tb_pcc_top;
	localparam int LC = 2;
	localparam int LIMIT = 40000;
	// Clock, reset and loop controls
	logic clk, rst_b, sleep_n, dreset, half, run, fb_on, ext_fb, lock;
	logic [2:0] psel;
	logic [4:0] pins, clks;
	// Register bus and image
	logic hsel, hwrite, hready, hresp;
	logic [1:0] htrans;
	logic [7:0] haddr;
	logic [31:0] hwdata, hrdata, q;
	logic [31:0] img [4];
	int bad_count, cmp_count, cyc, seed, c, n;

	pcc_top #(.LOCK_COUNT(LC)) pcc_top_inst (
		.CLK(clk), .RST_B(rst_b),
		.REF_GLOBAL_PIN(pins[0]), .REF_IO_PIN(pins[1]), .REF_CORE(pins[2]),
		.REF_RC_OSC(pins[3]), .REF_XTAL_OSC(pins[4]),
		.EXTERNAL_FEEDBACK_IN(ext_fb), .PLL_SLEEP_N(sleep_n),
		.OUT_A_DIVIDER_RESET(dreset), .OUT_A_HALF_STEP_DIVIDE(half),
		.PRIMARY_GLOBAL_CLK(clks[0]), .SECONDARY_GLOBAL_CLK_1(clks[1]),
		.CORE_ROUTE_CLK_1(clks[2]), .SECONDARY_GLOBAL_CLK_2(clks[3]),
		.CORE_ROUTE_CLK_2(clks[4]), .LOCK(lock),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
		.HRDATA(hrdata)
	);
	pcc_fabric_model pcc_fabric_model_inst (
		.run(run), .sel(psel), .fb_on(fb_on), .ref_pins(pins), .ext_fb(ext_fb)
	);

	// System clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Cycle ceiling against hangs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			bad_count++;
			test_done();
		end
	end

	task automatic test_done();
		$display("Counts: %0d compared, %0d mismatched", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk_word

	task automatic chk_num(input string what, input int e, input int g);
		cmp_count++;
		if (g != e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
		end
	endtask : chk_num

	// One single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rdata);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rdata = hrdata;
		chk_word("response", 32'h0, {31'h0, hresp});
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, q);
		if (a < 8'h0C) img[a[3:2]] = d;
	endtask : wr

	task automatic rchk(input logic [7:0] a);
		bus(1'b0, a, 32'h0, q);
		chk_word("register", (a < 8'h0C) ? img[a[3:2]] : 32'h0, q);
	endtask : rchk

	function automatic logic [31:0] ctl(input int src, input int rs, input int fb, input int en);
		return 32'(src | (rs << 3) | (fb << 6) | (en << 8));
	endfunction : ctl

	// Cycles until the next rise of one output, -1 if none
	task automatic rise(input int w, input int lim, output int cnt);
		logic p;
		cnt = -1;
		p = clks[w];
		for (int t = 1; t <= lim && cnt < 0; t++) begin
			@(negedge clk);
			if (clks[w] === 1'b1 && p === 1'b0) cnt = t;
			p = clks[w];
		end
	endtask : rise

	task automatic span(input int a, input int b, output int cnt);
		rise(a, 400, cnt);
		if (cnt > 0) rise(b, 400, cnt);
	endtask : span

	task automatic per(input int w, input int e);
		int p;
		rise(w, 400, p);
		span(w, w, p);
		chk_num("output period", e, p);
	endtask : per

	task automatic lock_wait(input int lim, output int cnt);
		cnt = -1;
		for (int t = 1; t <= lim && cnt < 0; t++) begin
			@(negedge clk);
			if (lock === 1'b1) cnt = t;
		end
	endtask : lock_wait

	// Divider A at ratio 8: a reset rise in the low half restarts it at once or not
	task automatic realign(input int fast);
		int p;
		per(0, 64);
		repeat (40) @(posedge clk);
		dreset <= 1'b1;
		rise(0, 100, p);
		chk_num("restart timing", fast, int'(p > 0 && p <= 16));
		@(posedge clk);
		dreset <= 1'b0;
	endtask : realign

	// Main sequence
	initial begin
		{rst_b, sleep_n, dreset, half, fb_on, hsel, hwrite} = '0;
		{htrans, haddr, hwdata, psel} = '0;
		run = 1'b1;
		seed = 60;
		img = '{pcc_pkg::CTRL_RST, pcc_pkg::DIV_RST, pcc_pkg::DLY_RST, 32'h0};
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rchk(8'h00);
		rchk(8'h04);
		rchk(8'h08);
		wr(8'h14, $random(seed));
		rchk(8'h14);
		for (int i = 0; i < 3; i++) begin
			wr(8'h08, $random(seed) & 32'h0001_ffff);
			rchk(8'h08);
		end
		wr(8'h08, 32'h0000_0000);
		bus(1'b0, 8'h0C, 32'h0, q);
		chk_word("asleep status", 32'h0000_0002, q & 32'h0000_0003);
		$display("Test registers done");
		sleep_n <= 1'b1;
		for (int s = 0; s < 5; s++) begin
			psel <= 3'(s);
			wr(8'h00, ctl(1, s, 0, 1));
			per(0, 8);
			psel <= 3'((s + 1) % 5);
			repeat (12) @(posedge clk);
			rise(0, 100, c);
			chk_num("unselected source", -1, c);
		end
		chk_word("bypass lock", 32'h0, {31'h0, lock});
		$display("Test source select done");
		psel <= 3'h3;
		wr(8'h00, ctl(1, 3, 0, 1));
		for (int i = 0; i < 3; i++) begin
			n = (i == 0) ? 0 : (i == 1) ? 15 : $unsigned($random(seed)) % 14 + 2;
			wr(8'h04, 32'h0000_0110 | n);
			per(0, 8 * ((n == 0) ? 1 : n));
		end
		half <= 1'b1;
		for (int i = 1; i < 15; i += 13) begin
			wr(8'h04, 32'h0000_0110 | i);
			per(0, 4 * (2 * i + 1));
		end
		half <= 1'b0;
		wr(8'h04, 32'h0000_0118);
		realign(1);
		$display("Test bypass divider done");
		psel <= 3'h0;
		wr(8'h00, ctl(0, 0, 1, 1));
		lock_wait(200, c);
		chk_num("lock without feedback", -1, c);
		fb_on <= 1'b1;
		lock_wait(LC * 8 + 40, c);
		chk_num("lock with feedback", 1, int'(c >= (LC - 1) * 8));
		wr(8'h00, ctl(0, 0, 0, 31));
		sleep_n <= 1'b0;
		repeat (5) @(posedge clk);
		n = 0;
		repeat (100) begin
			@(negedge clk);
			if ({clks, lock} !== 6'h00) n++;
		end
		chk_num("sleeping outputs", 0, n);
		@(posedge clk);
		sleep_n <= 1'b1;
		lock_wait(LC * 8 + 40, c);
		chk_num("relock", 1, int'(c >= (LC - 1) * 8));
		$display("Test lock and sleep done");
		wr(8'h04, 32'h0000_0532);
		per(1, 24);
		per(2, 24);
		per(3, 40);
		per(4, 40);
		wr(8'h08, 32'h0000_1800);
		rise(2, 400, c);
		span(1, 2, c);
		chk_num("core delay", 12, c);
		wr(8'h00, ctl(0, 0, 0, 5));
		bus(1'b0, 8'h0C, 32'h0, q);
		chk_word("effective enables", 32'h0000_0005, (q >> 4) & 32'h0000_001f);
		repeat (20) @(posedge clk);
		rise(1, 100, c);
		chk_num("disabled secondary", -1, c);
		rise(2, 100, c);
		chk_num("enabled core output", 1, int'(c > 0));
		wr(8'h04, 32'h0000_0538);
		realign(0);
		$display("Test outputs done");
		test_done();
	end
endmodule : tb_pcc_top
